/* File: rtl/auto_serial_pkg.sv */
// constants shared by the repeat-transmit serial block and its byte shifter
package auto_serial_pkg;
   // register byte offsets on the register bus
   localparam logic [7:0] SERIAL_MODE_REGISTER_OFS = 8'h00;
   localparam logic [7:0] SERIAL_TRIGGER_REGISTER_OFS = 8'h04;
   localparam logic [7:0] BYTE_COUNT_OFS = 8'h08;
   localparam logic [7:0] TRANSFER_INTERVAL_REGISTER_OFS = 8'h0c;
   localparam logic [7:0] TRANSFER_ADDRESS_COUNTER_OFS = 8'h10;
   // buffer ram occupies 8'h80..8'hfc, one byte per word
   localparam int BUF_SELECT_BIT = 7;
   localparam int BUF_DEPTH = 32;
   localparam int BUF_INDEX_W = 5;

   // serial_mode_register field positions
   localparam int SERIAL_UNIT_ENABLE_BIT = 7;
   localparam int AUTO_TRANSFER_ENABLE_BIT = 6;
   localparam int AUTO_MODE_SELECT_BIT = 5;
   localparam int TRANSMIT_ENABLE_BIT = 3;
   localparam int RECEIVE_ENABLE_BIT = 2;
   localparam int BUSY_CONTROL_BIT = 1;
   localparam int STROBE_CONTROL_BIT = 0;
   // serial_trigger_register field position
   localparam int TRANSFER_TRIGGER_BIT = 0;

   // values after reset
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [4:0] LAST_INDEX_RESET = 5'h1f;
   localparam logic [7:0] INTERVAL_RESET = 8'h04;

   // serial clock timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCK_HALF_NS = 80;
   localparam logic [3:0] SCK_HALF_CYCLES = 4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_SEND = 3'b010,
      ST_SHIFT = 3'b011,
      ST_GAP = 3'b100
   } engine_state_type;
endpackage

/* File: rtl/byte_shifter.sv */
// shifts one byte out msb first with a divided serial clock
`timescale 1ns/100ps
`default_nettype none
module byte_shifter (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic [7:0] i_byte,
   output logic o_sck,
   output logic o_sdo,
   output logic o_done
);
   import auto_serial_pkg::*;

   typedef struct packed {
      logic busy;
      logic sck;
      logic sdo;
      logic done;
      logic [7:0] sr;
      logic [2:0] bitcnt;
      logic [3:0] div;
   } shift_state_type;

   shift_state_type s_q;
   shift_state_type s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (i_start) begin
         s_d.busy = 1'b1;
         s_d.sck = 1'b1;
         s_d.sr = i_byte;
         s_d.sdo = i_byte[7];
         s_d.bitcnt = 3'h0;
         s_d.div = 4'h0;
      end else if (s_q.busy) begin
         if (s_q.div == SCK_HALF_CYCLES - 4'h1) begin
            s_d.div = 4'h0;
            s_d.sck = ~s_q.sck;
            if (s_q.sck) begin
               // falling edge: present the next bit, the first one is already out
               if (s_q.bitcnt != 3'h0) begin
                  s_d.sr = {s_q.sr[6:0], 1'b0};
                  s_d.sdo = s_q.sr[6];
               end
            end else begin
               // rising edge: receiver samples here, so data never moves on it
               if (s_q.bitcnt == LAST_BIT) begin
                  s_d.busy = 1'b0;
                  s_d.done = 1'b1;
               end else begin
                  s_d.bitcnt = s_q.bitcnt + 3'h1;
               end
            end
         end else begin
            s_d.div = s_q.div + 4'h1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         s_q <= '{busy: 1'b0, sck: 1'b1, sdo: 1'b1, done: 1'b0, sr: 8'h00,
                  bitcnt: 3'h0, div: 4'h0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_sck = s_q.sck;
   assign o_sdo = s_q.sdo;
   assign o_done = s_q.done;

   a_byte_finishes: assert property (
      @(posedge i_mclk) disable iff (!i_nrst) i_start |=> ##[120:140] s_q.done)
      else $error("shifter did not finish a byte in time");
   a_sck_idle_high: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!s_q.busy && !i_start) |=> s_q.sck)
      else $error("serial clock not high while idle");
endmodule
`default_nettype wire

/* File: rtl/auto_serial_interface.sv */
// repeat-transmit automatic serial interface with buffer ram and register bus slave
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module auto_serial_interface (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic o_sck,
   output logic o_sdo,
   output logic o_sdi_claim,
   output logic o_busy
);
   import auto_serial_pkg::*;

   typedef struct packed {
      engine_state_type st;
      logic [7:0] mode;
      logic [4:0] last_idx;
      logic [7:0] interval;
      logic [4:0] addr;
      logic [7:0] gap;
      logic [7:0] txbyte;
      logic start;
      logic wait_q;
      logic claim;
      logic busy;
      logic [31:0] rdata;
      logic [BUF_DEPTH-1:0][7:0] ram;
   } core_state_type;

   core_state_type s_q;
   core_state_type s_d;

   logic req;
   logic buf_hit;
   logic collide;
   logic run_ok;
   logic sh_done;
   logic last_byte;
   logic [BUF_INDEX_W-1:0] bus_idx;
   logic [7:0] fetch_byte;
   logic [31:0] rd_value;
   logic trig_wr;

   assign req = i_read | i_write;
   assign buf_hit = i_address[BUF_SELECT_BIT];
   assign bus_idx = i_address[BUF_INDEX_W+1:2];
   // any bus cycle aimed at the buffer owns the ram port for that clock
   assign collide = req & buf_hit;
   assign run_ok = s_q.mode[SERIAL_UNIT_ENABLE_BIT] & s_q.mode[AUTO_TRANSFER_ENABLE_BIT]
                 & s_q.mode[AUTO_MODE_SELECT_BIT] & s_q.mode[TRANSMIT_ENABLE_BIT];
   assign last_byte = (s_q.addr == s_q.last_idx);
   assign fetch_byte = s_q.ram[s_q.addr];
   // trigger write that takes effect at this edge; it overrides the engine step
   assign trig_wr = req & ~s_q.wait_q & i_write & i_byteenable[0] & ~buf_hit
                  & (i_address == SERIAL_TRIGGER_REGISTER_OFS);

   byte_shifter u_shifter (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_start(s_q.start),
      .i_byte(s_q.txbyte),
      .o_sck(o_sck),
      .o_sdo(o_sdo),
      .o_done(sh_done)
   );

   always_comb begin
      s_d = s_q;
      s_d.start = 1'b0;
      rd_value = 32'h0000_0000;

      // transfer engine
      case (s_q.st)
         ST_IDLE: begin
            s_d.st = ST_IDLE;
         end
         ST_FETCH: begin
            if (!collide) begin
               s_d.txbyte = fetch_byte;
               s_d.st = ST_SEND;
            end
         end
         ST_SEND: begin
            s_d.start = 1'b1;
            s_d.st = ST_SHIFT;
         end
         ST_SHIFT: begin
            if (sh_done) begin
               if (last_byte) begin
                  s_d.addr = '0;
               end else begin
                  s_d.addr = s_q.addr + 5'h1;
               end
               s_d.gap = s_q.interval;
               s_d.st = ST_GAP;
            end
         end
         ST_GAP: begin
            if (s_q.gap == 8'h00) begin
               s_d.st = ST_FETCH;
            end else begin
               s_d.gap = s_q.gap - 8'h01;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      if (!run_ok) begin
         s_d.st = ST_IDLE;
      end

      // read mux
      if (buf_hit) begin
         rd_value = {24'h00_0000, s_q.ram[bus_idx]};
      end else begin
         case (i_address)
            SERIAL_MODE_REGISTER_OFS: rd_value = {24'h00_0000, s_q.mode};
            SERIAL_TRIGGER_REGISTER_OFS: rd_value = {31'h0000_0000, s_q.busy};
            BYTE_COUNT_OFS: rd_value = {27'h000_0000, s_q.last_idx};
            TRANSFER_INTERVAL_REGISTER_OFS: rd_value = {24'h00_0000, s_q.interval};
            TRANSFER_ADDRESS_COUNTER_OFS: rd_value = {27'h000_0000, s_q.addr};
            default: rd_value = 32'h0000_0000;
         endcase
      end

      // avalon slave: one wait cycle, then the access completes
      if (req && s_q.wait_q) begin
         s_d.wait_q = 1'b0;
         s_d.rdata = rd_value;
      end else begin
         s_d.wait_q = 1'b1;
         if (req && i_write && i_byteenable[0]) begin
            if (buf_hit) begin
               s_d.ram[bus_idx] = i_writedata[7:0];
            end else begin
               case (i_address)
                  SERIAL_MODE_REGISTER_OFS: begin
                     s_d.mode = i_writedata[7:0];
                  end
                  SERIAL_TRIGGER_REGISTER_OFS: begin
                     if (i_writedata[TRANSFER_TRIGGER_BIT] && run_ok) begin
                        s_d.addr = '0;
                        s_d.st = ST_FETCH;
                     end else if (!i_writedata[TRANSFER_TRIGGER_BIT]) begin
                        s_d.st = ST_IDLE;
                     end
                  end
                  BYTE_COUNT_OFS: begin
                     s_d.last_idx = i_writedata[4:0];
                  end
                  TRANSFER_INTERVAL_REGISTER_OFS: begin
                     s_d.interval = i_writedata[7:0];
                  end
                  default: begin
                     s_d.mode = s_q.mode;
                  end
               endcase
            end
         end
      end

      s_d.claim = s_q.mode[RECEIVE_ENABLE_BIT] | s_q.mode[BUSY_CONTROL_BIT]
                | s_q.mode[STROBE_CONTROL_BIT];
      s_d.busy = (s_q.st != ST_IDLE);
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         s_q <= '{st: ST_IDLE, mode: MODE_RESET, last_idx: LAST_INDEX_RESET,
                  interval: INTERVAL_RESET, addr: 5'h00, gap: 8'h00, txbyte: 8'h00,
                  start: 1'b0, wait_q: 1'b1, claim: 1'b0, busy: 1'b0,
                  rdata: 32'h0000_0000, ram: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_readdata = s_q.rdata;
   assign o_waitrequest = s_q.wait_q;
   assign o_sdi_claim = s_q.claim;
   assign o_busy = s_q.busy;

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   // a trigger write landing in the same cycle wins over the engine step,
   // so the step checks on state or address leave that cycle to the trigger checks below; the gap load check keeps it
   sequence byte_sent_last;
      s_q.st == ST_SHIFT && sh_done && last_byte && run_ok && !trig_wr;
   endsequence

   sequence byte_sent_more;
      s_q.st == ST_SHIFT && sh_done && !last_byte && run_ok && !trig_wr;
   endsequence

   sequence gap_entered;
      s_q.st == ST_SHIFT && sh_done && run_ok;
   endsequence

   a_start_needs_enables: assert property (
      (s_q.st == ST_IDLE) ##1 (s_q.st != ST_IDLE) |-> $past(run_ok))
      else $error("transfer started without all enables");
   a_start_on_trigger: assert property (
      (req && !s_q.wait_q && i_write && i_byteenable[0] && !buf_hit
       && i_address == SERIAL_TRIGGER_REGISTER_OFS && i_writedata[0] && run_ok)
      |=> s_q.st == ST_FETCH && s_q.addr == 5'h00)
      else $error("trigger write did not start transfer");
   a_wrap_to_zero: assert property (
      byte_sent_last |=> s_q.addr == 5'h00)
      else $error("address counter did not wrap to zero");
   a_wrap_keeps_going: assert property (
      byte_sent_last |=> s_q.st == ST_GAP)
      else $error("repeat transfer stopped after last byte");
   a_repeat_resends: assert property (
      byte_sent_last |=> ##[1:300] (s_q.st == ST_SEND || !run_ok))
      else $error("buffer was not resent");
   a_addr_steps: assert property (
      byte_sent_more |=> s_q.addr == $past(s_q.addr) + 5'h1)
      else $error("address counter did not step by one");
   a_gap_loaded: assert property (
      gap_entered |=> s_q.gap == $past(s_q.interval))
      else $error("gap not loaded from interval");
   a_gap_counts: assert property (
      (s_q.st == ST_GAP && s_q.gap != 8'h00 && run_ok && !trig_wr)
      |=> s_q.st == ST_GAP && s_q.gap == $past(s_q.gap) - 8'h01)
      else $error("gap did not count down");
   a_fetch_byte: assert property (
      (s_q.st == ST_FETCH && !collide && run_ok && !trig_wr)
      |=> s_q.st == ST_SEND && s_q.txbyte == $past(fetch_byte) ##1 s_q.start)
      else $error("byte fetch or shifter start wrong");
   a_collide_holds: assert property (
      (s_q.st == ST_FETCH && collide && run_ok) |=> s_q.st == ST_FETCH)
      else $error("fetch proceeded during bus buffer access");
   a_pin_release: assert property (
      (s_q.mode[RECEIVE_ENABLE_BIT] == 1'b0 && s_q.mode[BUSY_CONTROL_BIT] == 1'b0
       && s_q.mode[STROBE_CONTROL_BIT] == 1'b0) [*2] |-> !o_sdi_claim)
      else $error("data input pin held while unused");
   a_bus_one_wait: assert property (
      (req && s_q.wait_q) |=> !o_waitrequest ##1 o_waitrequest)
      else $error("bus answer timing wrong");
   a_wait_idle_high: assert property (
      !req |=> o_waitrequest)
      else $error("waitrequest low without a request");

   // a refused trigger must leave the engine parked
   a_trigger_refused: assert property (
      (trig_wr && i_writedata[TRANSFER_TRIGGER_BIT] && !run_ok && s_q.st == ST_IDLE)
      |=> s_q.st == ST_IDLE)
      else $error("trigger accepted without all enables");
   a_stop_on_clear: assert property (
      (trig_wr && !i_writedata[TRANSFER_TRIGGER_BIT]) |=> s_q.st == ST_IDLE)
      else $error("clearing the trigger did not stop the engine");
   a_mode_left_stops: assert property (
      !run_ok |=> s_q.st == ST_IDLE)
      else $error("engine kept running after an enable was cleared");
   // the shifter may only be started out of the send step, once per byte
   a_start_from_send: assert property (
      s_q.start |-> $past(s_q.st) == ST_SEND && !$past(s_q.start))
      else $error("shifter started outside the send step");
   a_busy_while_shifting: assert property (
      (s_q.st == ST_SHIFT) |=> o_busy)
      else $error("busy flag low while a byte is in flight");
   a_pin_claim: assert property (
      (s_q.mode[RECEIVE_ENABLE_BIT] || s_q.mode[BUSY_CONTROL_BIT]
       || s_q.mode[STROBE_CONTROL_BIT]) |=> o_sdi_claim)
      else $error("data input pin released while in use");
   // bus side: a buffer write lands in the cycle that completes the access
   a_buf_write_lands: assert property (
      (req && !s_q.wait_q && i_write && i_byteenable[0] && buf_hit)
      |=> {24'h00_0000, s_q.ram[$past(bus_idx)]} == ($past(i_writedata) & 32'h0000_00ff))
      else $error("buffer write was lost");
   a_mode_readback: assert property (
      (req && s_q.wait_q && !buf_hit && i_address == SERIAL_MODE_REGISTER_OFS)
      |=> o_readdata == {24'h00_0000, $past(s_q.mode)})
      else $error("mode register read back wrong");
endmodule
`default_nettype wire

/* File: tb/serial_receiver_model.sv */
// receiving end of the serial link: takes data on each serial clock rise
`timescale 1ns/100ps
`default_nettype none
module serial_receiver_model (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_sck,
   input wire logic i_sdo,
   output logic [7:0] o_byte,
   output logic o_valid
);
   logic sck_q;
   logic [7:0] sh_q;
   logic [2:0] cnt_q;
   // msb arrives first; a byte is whole after the eighth rise
   always_ff @(posedge i_mclk) begin
      o_valid <= 1'b0;
      if (!i_nrst) begin
         sck_q <= 1'b1;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         o_byte <= 8'h00;
      end else begin
         sck_q <= i_sck;
         if (i_sck && !sck_q) begin
            sh_q <= {sh_q[6:0], i_sdo};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
               o_byte <= {sh_q[6:0], i_sdo};
               o_valid <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb_auto_serial_interface.sv */
// self-checking bench for the repeat-transmit serial block
`timescale 1ns/100ps
`default_nettype none
module tb_auto_serial_interface;
   import auto_serial_pkg::*;
   logic i_mclk, i_nrst, i_read, i_write;
   logic [7:0] i_address;
   logic [3:0] i_byteenable;
   logic [31:0] i_writedata, o_readdata, rd;
   logic o_waitrequest, o_sck, o_sdo, o_sdi_claim, o_busy, rx_valid;
   logic [7:0] rx_byte;
   logic [7:0] mem [0:2];
   logic [7:0] rx_q [$];
   int fails = 0, total_checks = 0, cycles = 0, seed, n, k;
   int last = 2;

   auto_serial_interface dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
      .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .o_sck(o_sck), .o_sdo(o_sdo), .o_sdi_claim(o_sdi_claim), .o_busy(o_busy));
   serial_receiver_model rx (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sck(o_sck),
      .i_sdo(o_sdo), .o_byte(rx_byte), .o_valid(rx_valid));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
   end
   // hang guard: the whole run needs a few thousand cycles
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles > 40000) begin
         fails++;
         summarize();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // holds the request until waitrequest is sampled low, then releases it
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int w;
      w = 0;
      @(posedge i_mclk);
      i_address <= a;
      i_writedata <= d;
      i_read <= !wr;
      i_write <= wr;
      do begin
         @(posedge i_mclk);
         w++;
      end while (o_waitrequest !== 1'b0 && w < 100);
      if (w >= 100) chk("bus_answer", 1, 0);
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask

   function automatic logic [7:0] exp_byte(input int i);
      return mem[i % (last + 1)];
   endfunction

   initial begin
      seed = 2;
      i_nrst = 1'b0;
      i_read = 1'b0;
      i_write = 1'b0;
      i_address = 8'h00;
      i_byteenable = 4'hf;
      i_writedata = 32'h0;
      repeat (4) @(posedge i_mclk);
      chk("pins_reset", {o_waitrequest, o_sck, o_sdo, o_sdi_claim, o_busy}, 5'b11100);
      i_nrst <= 1'b1;
      bus(0, SERIAL_MODE_REGISTER_OFS, 0, rd);
      chk("mode_reset", rd, 32'(MODE_RESET));
      bus(0, BYTE_COUNT_OFS, 0, rd);
      chk("count_reset", rd, 32'(LAST_INDEX_RESET));
      bus(0, TRANSFER_ADDRESS_COUNTER_OFS, 0, rd);
      chk("addr_reset", rd, 32'h0);
      bus(0, 8'h14, 0, rd);
      chk("unmapped", rd, 32'h0);
      i_byteenable <= 4'h0;
      bus(1, TRANSFER_INTERVAL_REGISTER_OFS, 32'h33, rd);
      i_byteenable <= 4'hf;
      bus(0, TRANSFER_INTERVAL_REGISTER_OFS, 0, rd);
      chk("interval_reset", rd, 32'(INTERVAL_RESET));
      for (k = 0; k < 4; k++) begin
         n = (k == 3) ? 3 : 7 - k;
         bus(1, SERIAL_MODE_REGISTER_OFS, 32'(8'he8 & ~(8'h01 << n)), rd);
         bus(1, SERIAL_TRIGGER_REGISTER_OFS, 32'h1, rd);
         repeat (4) @(posedge i_mclk);
         chk("busy_refused", o_busy, 1'b0);
      end
      for (k = 0; k < 3; k++) begin
         bus(1, SERIAL_MODE_REGISTER_OFS, 32'(8'he8 | (8'h01 << k)), rd);
         repeat (3) @(posedge i_mclk);
         chk("sdi_claimed", o_sdi_claim, 1'b1);
         bus(1, SERIAL_MODE_REGISTER_OFS, 32'he8, rd);
         repeat (3) @(posedge i_mclk);
         chk("sdi_released", o_sdi_claim, 1'b0);
      end
      for (k = 0; k <= last; k++) begin
         mem[k] = 8'($random(seed));
         bus(1, 8'(8'h80 + 4 * k), 32'(mem[k]), rd);
      end
      bus(1, BYTE_COUNT_OFS, 32'(last), rd);
      bus(1, TRANSFER_INTERVAL_REGISTER_OFS, 32'($random(seed) & 8'h0f), rd);
      rx_q.delete();
      bus(1, SERIAL_TRIGGER_REGISTER_OFS, 32'h1, rd);
      repeat (2) @(posedge i_mclk);
      chk("busy_started", o_busy, 1'b1);
      bus(0, SERIAL_TRIGGER_REGISTER_OFS, 0, rd);
      chk("trigger_busy", rd, 32'h1);
      n = 0;
      // buffer reads collide with the fetch and may only stretch the gap
      while (rx_q.size() < 7 && n < 1500) begin
         k = {$random(seed)} % (last + 1);
         bus(0, 8'(8'h80 + 4 * k), 0, rd);
         chk("buf_read", rd, 32'(mem[k]));
         n++;
      end
      chk("rx_count", rx_q.size() >= 7, 1'b1);
      for (k = 0; k < 7 && k < rx_q.size(); k++) begin
         chk("rx_byte", rx_q[k], exp_byte(k));
      end
      bus(1, SERIAL_TRIGGER_REGISTER_OFS, 32'h0, rd);
      n = 0;
      while (o_busy !== 1'b0 && n < 400) begin
         @(posedge i_mclk);
         n++;
      end
      // a byte already on the line finishes before the link goes quiet
      repeat (150) @(posedge i_mclk);
      chk("stopped", {o_busy, o_sck}, 2'b01);
      k = rx_q.size();
      repeat (300) @(posedge i_mclk);
      chk("no_more_bytes", rx_q.size(), k);
      bus(0, SERIAL_TRIGGER_REGISTER_OFS, 0, rd);
      chk("trigger_idle", rd, 32'h0);
      bus(0, TRANSFER_ADDRESS_COUNTER_OFS, 0, rd);
      chk("addr_in_range", rd <= 32'(last), 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
